// File: gts_defs.svh
// Purpose: constants for the global trigger scheduler
// Assumes: 10 MHz system clock, Avalon-MM byte addresses of 12 bits
// Notes:   offsets are byte addresses, one 32-bit word per register
`ifndef GTS_DEFS_SVH
`define GTS_DEFS_SVH

`define CLK_MHZ      10
`define WINDOW_NS    500
`define WINDOW_CYC   ((`WINDOW_NS * `CLK_MHZ) / 1000)
`define TIME_MHZ     20
`define TIME_STEP    (`TIME_MHZ / `CLK_MHZ)
`define PERIOD_RST   24'h00FFFF
`define BCAST_DEST   5'h1F

`define R_CTRL       12'h000
`define R_WINDOW     12'h004
`define R_PERIOD     12'h008
`define R_CMASK      12'h00C
`define R_INMASK     12'h010
`define R_TURNEN     12'h01C
`define R_TILEEN     12'h028
`define R_EVNUM      12'h034
`define R_LASTCOND   12'h038
`define R_LASTLOW    12'h03C
`define R_LASTHIGH   12'h040
`define R_CNT_DEAD   12'h044
`define R_CNT_PRESC  12'h048
`define R_CNT_SENT   12'h04C
`define R_DEAD_CLKS  12'h050
`define R_TIME       12'h054
`define R_PPS_LATCH  12'h058
`define R_PPS_COUNT  12'h05C
`define R_TILES      12'h060
`define FIXED_WORDS  27
`define R_TILEMAP    12'h100
`define R_TILEMAP_END 12'h280
`define R_LUT        12'h400
`define R_SLOT       12'h800
`define R_DEST       12'h880

`define F_PRESC      0
`define F_DEST       8
`define F_ZS         13
`define F_AR         14
`define F_DYN        15
`define F_MISC       16

`define IN_TKR       0
`define IN_CLO       16
`define IN_CHI       32
`define IN_HVY       48
`define IN_VETO      60
`define IN_UPPER     76
`define IN_LOWER     77

`endif

// File: gts_pkg.sv
// Purpose: types for the global trigger scheduler
// Assumes: nothing
// Notes:   window states are Gray coded along idle, open, close
package gts_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_OPEN  = 2'b01,
      ST_CLOSE = 2'b11
   } win_state_e;
   typedef logic [31:0] word_t;
endpackage : gts_pkg

// File: global_trigger_scheduler.sv
// Purpose: veto generator, window scheduler, message generator and counters
// Assumes: inputs synchronous to clk; one wait state on every bus access
// Notes:   message fields stand until the next message
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`include "gts_defs.svh"
module global_trigger_scheduler import gts_pkg::*; (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // front-end primitives
   input  wire logic [95:0] anticoincidence_tiles,
   input  wire logic [15:0] tracker,
   input  wire logic [15:0] calorimeter_low,
   input  wire logic [15:0] calorimeter_high,
   input  wire logic [11:0] heavy_ion_flag,
   // system inputs
   input  wire logic        solicited_req,
   input  wire logic        throttle,
   input  wire logic        second_mark,
   // avalon-mm slave
   input  wire logic [11:0] address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output word_t            readdata,
   output logic             waitrequest,
   // trigger message
   output logic             msg_valid,
   output logic [3:0]       msg_slot,
   output logic [4:0]       msg_dest,
   output logic             msg_broadcast,
   output logic             msg_zero_suppress,
   output logic             msg_autorange,
   output logic [7:0]       msg_misc,
   output word_t            msg_event,
   output word_t            msg_time
);

   win_state_e  state_q;
   logic        ctrl_en_q;
   logic [7:0]  win_width_q;
   logic [23:0] period_q;
   logic [7:0]  cond_mask_q;
   logic [95:0] in_mask_q;
   logic [95:0] turn_en_q;
   logic [95:0] tile_en_q;
   logic [4:0]  tile_map_q [96];
   logic [3:0]  lut_q [256];
   word_t       slot_q [16];
   logic [4:0]  dest_buf_q [32];
   logic [7:0]  presc_cnt_q [16];
   logic [4:0]  dptr_q;
   logic [7:0]  win_cnt_q;
   logic [95:0] acc_q;
   logic [95:0] tile_acc_q;
   logic [23:0] per_cnt_q;
   logic        per_pulse_q;
   word_t       event_num_q;
   word_t       cnt_dead_q;
   word_t       cnt_presc_q;
   word_t       cnt_sent_q;
   word_t       dead_clks_q;
   word_t       time20_q;
   word_t       pps_latch_q;
   word_t       pps_count_q;
   logic [95:0] last_acc_q;
   logic [95:0] last_tiles_q;
   logic [7:0]  last_cond_q;
   logic [3:0]  last_slot_q;
   word_t       readdata_q;
   logic        waitrequest_q;
   logic        msg_valid_q;
   logic [3:0]  msg_slot_q;
   logic [4:0]  msg_dest_q;
   logic        msg_broadcast_q;
   logic        msg_zs_q;
   logic        msg_ar_q;
   logic [7:0]  msg_misc_q;
   word_t       msg_event_q;
   word_t       msg_time_q;
   word_t       turns_q;
   logic [7:0]  open_len_q;

   // veto generator: tile gates
   wire [17:0] gate_or;
   generate
      for (genvar g = 0; g < 18; g++) begin : g_gate
         wire [95:0] member;
         for (genvar t = 0; t < 96; t++) begin : g_tile
            assign member[t] = (tile_map_q[t] == 5'(g));
         end
         assign gate_or[g] = |(anticoincidence_tiles & tile_en_q & member);
      end
   endgenerate

   // input vector, masking and turn start
   wire [95:0] in_raw     = {16'h0000, per_pulse_q, solicited_req, gate_or[17:16], gate_or[15:0],
                             heavy_ion_flag, calorimeter_high, calorimeter_low, tracker};
   wire [95:0] in_masked  = in_raw & in_mask_q;
   wire        turn_start = ctrl_en_q & (|(in_masked & turn_en_q));
   wire [95:0] tile_live  = anticoincidence_tiles & tile_en_q;

   // coincidence at window close
   wire [15:0] tkr_a      = acc_q[`IN_TKR +: 16];
   wire [15:0] chi_a      = acc_q[`IN_CHI +: 16];
   wire [15:0] veto_a     = acc_q[`IN_VETO +: 16];
   wire        tkr_vetoed = |(tkr_a & veto_a);
   wire        cal_vetoed = acc_q[`IN_UPPER] & ~(|chi_a);
   wire [7:0]  cond_raw   = {acc_q[79], acc_q[78], cal_vetoed, tkr_vetoed,
                             |acc_q[`IN_HVY +: 12], |chi_a, |acc_q[`IN_CLO +: 16], |tkr_a};
   wire [7:0]  cond       = cond_raw & cond_mask_q;
   wire [3:0]  slot       = lut_q[cond];
   wire [31:0] entry      = slot_q[slot];
   wire        closing    = (state_q == ST_CLOSE);
   wire        presc_blk  = (presc_cnt_q[slot] != 8'h00);
   wire        dead_turn  = closing & throttle;
   wire        presc_turn = closing & ~throttle & presc_blk;
   wire        sending    = closing & ~throttle & ~presc_blk;
   wire        dyn_dest   = entry[`F_DYN];
   wire [4:0]  dest_sel   = dyn_dest ? dest_buf_q[dptr_q] : entry[`F_DEST +: 5];

   // bus decode
   wire        wr_ok      = write & ~waitrequest_q;
   wire        in_fixed   = (address[11:7] == 5'h00);
   wire [4:0]  fidx       = address[6:2];
   wire [11:0] im_off     = address - `R_INMASK;
   wire [11:0] te_off     = address - `R_TURNEN;
   wire [11:0] ti_off     = address - `R_TILEEN;
   wire [11:0] tm_off     = address - `R_TILEMAP;
   wire        in_im      = (address >= `R_INMASK) && (address < `R_TURNEN);
   wire        in_te      = (address >= `R_TURNEN) && (address < `R_TILEEN);
   wire        in_ti      = (address >= `R_TILEEN) && (address < `R_EVNUM);
   wire        in_tmap    = (address >= `R_TILEMAP) && (address < `R_TILEMAP_END);
   wire        in_lut     = (address[11:10] == 2'b01);
   wire        in_slot    = (address[11:6] == 6'h20);
   wire        in_dest    = (address[11:7] == 5'h11);

   // read mux
   word_t fixed_rd [`FIXED_WORDS];
   assign fixed_rd[0]  = {31'h0, ctrl_en_q};
   assign fixed_rd[1]  = {24'h0, win_width_q};
   assign fixed_rd[2]  = {8'h00, period_q};
   assign fixed_rd[3]  = {24'h0, cond_mask_q};
   assign fixed_rd[4]  = in_mask_q[31:0];
   assign fixed_rd[5]  = in_mask_q[63:32];
   assign fixed_rd[6]  = in_mask_q[95:64];
   assign fixed_rd[7]  = turn_en_q[31:0];
   assign fixed_rd[8]  = turn_en_q[63:32];
   assign fixed_rd[9]  = turn_en_q[95:64];
   assign fixed_rd[10] = tile_en_q[31:0];
   assign fixed_rd[11] = tile_en_q[63:32];
   assign fixed_rd[12] = tile_en_q[95:64];
   assign fixed_rd[13] = event_num_q;
   assign fixed_rd[14] = {last_acc_q[`IN_VETO +: 16], 2'b00, last_acc_q[`IN_LOWER], last_acc_q[`IN_UPPER],
                          last_slot_q, last_cond_q};
   assign fixed_rd[15] = {last_acc_q[`IN_CLO +: 16], last_acc_q[`IN_TKR +: 16]};
   assign fixed_rd[16] = {4'h0, last_acc_q[`IN_HVY +: 12], last_acc_q[`IN_CHI +: 16]};
   assign fixed_rd[17] = cnt_dead_q;
   assign fixed_rd[18] = cnt_presc_q;
   assign fixed_rd[19] = cnt_sent_q;
   assign fixed_rd[20] = dead_clks_q;
   assign fixed_rd[21] = time20_q;
   assign fixed_rd[22] = pps_latch_q;
   assign fixed_rd[23] = pps_count_q;
   assign fixed_rd[24] = last_tiles_q[31:0];
   assign fixed_rd[25] = last_tiles_q[63:32];
   assign fixed_rd[26] = last_tiles_q[95:64];
   wire [31:0] rd_val = (in_fixed && fidx < 5'(`FIXED_WORDS)) ? fixed_rd[fidx] :
                        in_tmap ? {27'h0, tile_map_q[tm_off[8:2]]} :
                        in_lut  ? {28'h0, lut_q[address[9:2]]} :
                        in_slot ? slot_q[address[5:2]] :
                        in_dest ? {27'h0, dest_buf_q[address[6:2]]} : 32'h0;

   // bus handshake, one wait state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         waitrequest_q <= 1'b1;
         readdata_q    <= 32'h0;
      end else begin
         waitrequest_q <= ~((read | write) & waitrequest_q);
         if (read & waitrequest_q) readdata_q <= rd_val;
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_en_q   <= 1'b0;
         win_width_q <= 8'(`WINDOW_CYC);
         period_q    <= `PERIOD_RST;
         cond_mask_q <= 8'hFF;
         in_mask_q   <= {96{1'b1}};
         turn_en_q   <= {20'h00000, 12'hFFF, 64'h0000FFFFFFFFFFFF};
         tile_en_q   <= {96{1'b1}};
      end else if (wr_ok) begin
         if (address == `R_CTRL)   ctrl_en_q   <= writedata[0];
         if (address == `R_WINDOW) win_width_q <= writedata[7:0];
         if (address == `R_PERIOD) period_q    <= writedata[23:0];
         if (address == `R_CMASK)  cond_mask_q <= writedata[7:0];
         if (in_im) in_mask_q[im_off[3:2] * 32 +: 32] <= writedata;
         if (in_te) turn_en_q[te_off[3:2] * 32 +: 32] <= writedata;
         if (in_ti) tile_en_q[ti_off[3:2] * 32 +: 32] <= writedata;
      end
   end

   // tables
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 96; i++) tile_map_q[i] <= 5'h00;
         for (int i = 0; i < 256; i++) lut_q[i] <= 4'h0;
         for (int i = 0; i < 16; i++) slot_q[i] <= 32'h0;
         for (int i = 0; i < 32; i++) dest_buf_q[i] <= 5'h00;
      end else if (wr_ok) begin
         if (in_tmap) tile_map_q[tm_off[8:2]] <= writedata[4:0];
         if (in_lut)  lut_q[address[9:2]]     <= writedata[3:0];
         if (in_slot) slot_q[address[5:2]]    <= writedata;
         if (in_dest) dest_buf_q[address[6:2]] <= writedata[4:0];
      end
   end

   // periodic source from scaled system clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         per_cnt_q   <= 24'h0;
         per_pulse_q <= 1'b0;
      end else begin
         per_pulse_q <= (per_cnt_q == period_q);
         per_cnt_q   <= (per_cnt_q == period_q) ? 24'h0 : per_cnt_q + 24'h1;
      end
   end

   // window state machine and integration
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q    <= ST_IDLE;
         win_cnt_q  <= 8'h0;
         acc_q      <= 96'h0;
         tile_acc_q <= 96'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (turn_start) begin
                  state_q    <= ST_OPEN;
                  win_cnt_q  <= (win_width_q == 8'h0) ? 8'h1 : win_width_q;
                  acc_q      <= in_masked;
                  tile_acc_q <= tile_live;
               end
            end
            ST_OPEN: begin
               acc_q      <= acc_q | in_masked;
               tile_acc_q <= tile_acc_q | tile_live;
               win_cnt_q  <= win_cnt_q - 8'h1;
               if (win_cnt_q == 8'h1) state_q <= ST_CLOSE;
            end
            ST_CLOSE: state_q <= ST_IDLE;
            default:  state_q <= ST_IDLE;
         endcase
      end
   end

   // prescale counters and destination pointer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 16; i++) presc_cnt_q[i] <= 8'h00;
         dptr_q <= 5'h00;
      end else begin
         if (presc_turn) presc_cnt_q[slot] <= presc_cnt_q[slot] - 8'h01;
         if (sending) presc_cnt_q[slot] <= entry[`F_PRESC +: 8];
         if (sending && dyn_dest) dptr_q <= dptr_q + 5'h01;
      end
   end

   // message and event record
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         msg_valid_q     <= 1'b0;
         msg_slot_q      <= 4'h0;
         msg_dest_q      <= 5'h00;
         msg_broadcast_q <= 1'b0;
         msg_zs_q        <= 1'b0;
         msg_ar_q        <= 1'b0;
         msg_misc_q      <= 8'h00;
         msg_event_q     <= 32'h0;
         msg_time_q      <= 32'h0;
         event_num_q     <= 32'h0;
         last_acc_q      <= 96'h0;
         last_tiles_q    <= 96'h0;
         last_cond_q     <= 8'h00;
         last_slot_q     <= 4'h0;
      end else begin
         msg_valid_q <= sending;
         if (sending) begin
            msg_slot_q      <= slot;
            msg_dest_q      <= dest_sel;
            msg_broadcast_q <= (dest_sel == `BCAST_DEST);
            msg_zs_q        <= entry[`F_ZS];
            msg_ar_q        <= entry[`F_AR];
            msg_misc_q      <= entry[`F_MISC +: 8];
            msg_event_q     <= event_num_q;
            msg_time_q      <= time20_q;
            event_num_q     <= event_num_q + 32'h1;
            last_acc_q      <= acc_q;
            last_tiles_q    <= tile_acc_q;
            last_cond_q     <= cond;
            last_slot_q     <= slot;
         end
      end
   end

   // turn, deadtime and time counters
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_dead_q  <= 32'h0;
         cnt_presc_q <= 32'h0;
         cnt_sent_q  <= 32'h0;
         dead_clks_q <= 32'h0;
         time20_q    <= 32'h0;
         pps_latch_q <= 32'h0;
         pps_count_q <= 32'h0;
      end else begin
         if (dead_turn)  cnt_dead_q  <= cnt_dead_q + 32'h1;
         if (presc_turn) cnt_presc_q <= cnt_presc_q + 32'h1;
         if (sending)    cnt_sent_q  <= cnt_sent_q + 32'h1;
         if (throttle)   dead_clks_q <= dead_clks_q + 32'h1;
         time20_q <= time20_q + 32'(`TIME_STEP);
         if (second_mark) begin
            pps_latch_q <= time20_q;
            pps_count_q <= pps_count_q + 32'h1;
         end
      end
   end

   // outputs
   assign readdata          = readdata_q;
   assign waitrequest       = waitrequest_q;
   assign msg_valid         = msg_valid_q;
   assign msg_slot          = msg_slot_q;
   assign msg_dest          = msg_dest_q;
   assign msg_broadcast     = msg_broadcast_q;
   assign msg_zero_suppress = msg_zs_q;
   assign msg_autorange     = msg_ar_q;
   assign msg_misc          = msg_misc_q;
   assign msg_event         = msg_event_q;
   assign msg_time          = msg_time_q;

   // checking helpers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         turns_q    <= 32'h0;
         open_len_q <= 8'h0;
      end else begin
         if (closing) turns_q <= turns_q + 32'h1;
         open_len_q <= (state_q == ST_OPEN) ? open_len_q + 8'h1 : 8'h0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_ack;
      !waitrequest_q ##1 waitrequest_q;
   endsequence
   sequence s_close_then_idle;
      (state_q == ST_CLOSE) ##1 (state_q == ST_IDLE);
   endsequence

   property p_bus_ack;
      (read || write) && waitrequest_q |=> s_ack;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer not after one wait state");

   property p_no_turn;
      (state_q == ST_IDLE) && !turn_start |=> (state_q == ST_IDLE);
   endproperty
   a_no_turn: assert property (p_no_turn) else $error("window opened without enabled input");

   property p_window_len;
      (state_q == ST_OPEN) && $past(state_q) == ST_OPEN && win_cnt_q == 8'h1
         |=> s_close_then_idle;
   endproperty
   a_window_len: assert property (p_window_len) else $error("window did not close in time");

   property p_win_width;
      $rose(state_q == ST_CLOSE) && $stable(win_width_q)
         |-> open_len_q == ((win_width_q == 8'h0) ? 8'h1 : win_width_q);
   endproperty
   a_win_width: assert property (p_win_width) else $error("window open length differs from width");

   property p_sticky;
      (state_q == ST_OPEN) |=> ((acc_q & $past(acc_q)) == $past(acc_q));
   endproperty
   a_sticky: assert property (p_sticky) else $error("integrated input dropped");

   property p_throttle_blocks;
      (state_q == ST_CLOSE) && throttle |=> !msg_valid_q;
   endproperty
   a_throttle_blocks: assert property (p_throttle_blocks) else $error("message sent under throttle");

   property p_turn_sum;
      (cnt_dead_q + cnt_presc_q + cnt_sent_q) == turns_q;
   endproperty
   a_turn_sum: assert property (p_turn_sum) else $error("window turn counts do not sum");

   property p_event_lock;
      msg_valid_q |-> (event_num_q == msg_event_q + 32'h1) && (msg_time_q == $past(time20_q));
   endproperty
   a_event_lock: assert property (p_event_lock) else $error("event number and stamp not locked");

   property p_time_step;
      $past(nrst) |-> time20_q == $past(time20_q) + 32'(`TIME_STEP);
   endproperty
   a_time_step: assert property (p_time_step) else $error("time count step wrong");

   property p_bcast;
      msg_valid_q |-> msg_broadcast_q == (msg_dest_q == `BCAST_DEST);
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");

endmodule : global_trigger_scheduler

// File: gts_front_end.sv
// Purpose: front-end primitives and message sink beside the scheduler
// Assumes: go is a one-clock request from the bench
// Notes:   tile hits trail tracker hits by one clock
`timescale 1ns/1ns
module gts_front_end (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // stimulus
   input  wire logic        go,
   input  wire logic [15:0] trk_in,
   input  wire logic [95:0] tile_in,
   input  wire logic [15:0] chi_in,
   // primitives
   output logic      [15:0] tracker,
   output logic      [95:0] anticoincidence_tiles,
   output logic      [15:0] calorimeter_high,
   // message sink
   input  wire logic        msg_valid,
   output int               msg_seen
);
   logic [95:0] tile_q;
   // levels return low once the hit has been shown
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tracker               <= '0;
         calorimeter_high      <= '0;
         tile_q                <= '0;
         anticoincidence_tiles <= '0;
         msg_seen              <= 0;
      end else begin
         tracker               <= go ? trk_in : 16'h0000;
         calorimeter_high      <= go ? chi_in : 16'h0000;
         tile_q                <= go ? tile_in : '0;
         anticoincidence_tiles <= tile_q;
         if (msg_valid) msg_seen <= msg_seen + 1;
      end
   end
endmodule : gts_front_end

// File: test_global_trigger_scheduler.sv
// Purpose: self-checking bench for the trigger scheduler
// Assumes: one wait state per bus access, window of 2 clocks
// Notes:   bus tasks hold each request until waitrequest is seen low
`timescale 1ns/1ns
`include "gts_defs.svh"
module test_global_trigger_scheduler;
   logic        clk, nrst, read, write, go, throttle, second_mark, got;
   logic        waitrequest, msg_valid, msg_broadcast, msg_zero_suppress, msg_autorange;
   logic [11:0] address;
   logic [31:0] writedata, readdata, msg_event, msg_time;
   logic [3:0]  msg_slot;
   logic [4:0]  msg_dest;
   logic [7:0]  msg_misc;
   logic [15:0] tracker, calorimeter_high, trk_in, chi_in;
   logic [95:0] anticoincidence_tiles, tile_in;
   logic        solicited;
   logic [11:0] heavy;
   logic [15:0] cal_low;
   logic [31:0] stamp;
   int          fails, checks, msg_seen;
   global_trigger_scheduler dut_u (.clk(clk), .nrst(nrst), .anticoincidence_tiles(anticoincidence_tiles),
      .tracker(tracker), .calorimeter_low(cal_low), .calorimeter_high(calorimeter_high),
      .heavy_ion_flag(heavy), .solicited_req(solicited), .throttle(throttle), .second_mark(second_mark),
      .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .msg_valid(msg_valid), .msg_slot(msg_slot), .msg_dest(msg_dest),
      .msg_broadcast(msg_broadcast), .msg_zero_suppress(msg_zero_suppress), .msg_autorange(msg_autorange),
      .msg_misc(msg_misc), .msg_event(msg_event), .msg_time(msg_time));
   gts_front_end fe_u (.clk(clk), .nrst(nrst), .go(go), .trk_in(trk_in), .tile_in(tile_in),
      .chi_in(chi_in), .tracker(tracker), .anticoincidence_tiles(anticoincidence_tiles),
      .calorimeter_high(calorimeter_high), .msg_valid(msg_valid), .msg_seen(msg_seen));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic test_done;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      checks++;
      if (got_v !== exp_v) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      address   <= a;
      writedata <= d;
      write     <= w;
      read      <= !w;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
      read  <= 1'b0;
   endtask : bus
   task automatic rd(input logic [11:0] a, input logic [31:0] exp_v);
      bus(1'b0, a, 32'h0);
      chk(readdata, exp_v);
   endtask : rd
   // one hit burst, then watch for a message over the whole turn
   task automatic fire(input logic [15:0] t, input logic [95:0] ti, input logic [15:0] ch);
      @(posedge clk);
      trk_in  <= t;
      tile_in <= ti;
      chi_in  <= ch;
      go      <= 1'b1;
      @(posedge clk);
      go  <= 1'b0;
      got = 1'b0;
      repeat (12) begin
         @(posedge clk);
         if (msg_valid === 1'b1) got = 1'b1;
      end
   endtask : fire
   initial begin
      #(100 * 20000);
      fails++;
      test_done;
   end
   initial begin
      {nrst, read, write, go, throttle, second_mark, solicited} = 7'h00;
      {address, writedata, trk_in, chi_in, tile_in, cal_low, heavy} = '0;
      repeat (5) @(posedge clk);
      chk(waitrequest, 32'h1);
      nrst <= 1'b1;
      rd(`R_CTRL, 32'h0);
      rd(`R_WINDOW, 32'h5);
      rd(`R_PERIOD, `PERIOD_RST);
      bus(1'b1, 12'h300, 32'hFFFF_FFFF);
      rd(12'h300, 32'h0);
      $display("test reset done");
      bus(1'b1, `R_CTRL, 32'h1);
      bus(1'b1, `R_WINDOW, 32'h2);
      bus(1'b1, `R_LUT + 12'h044, 32'h3);
      bus(1'b1, `R_SLOT + 12'h00C, 32'h00A5_2500);
      fire(16'h0001, 96'h1, 16'h0000);
      chk({got, msg_slot, msg_dest}, {1'b1, 4'h3, 5'h05});
      chk({msg_misc, msg_zero_suppress, msg_autorange, msg_broadcast}, {8'hA5, 3'b100});
      chk(msg_event, 32'h0);
      rd(`R_LASTCOND, 32'h0001_0311);
      bus(1'b1, `R_INMASK, 32'hFFFF_FFFD);
      fire(16'h0002, 96'h0, 16'h0000);
      chk(got, 32'h0);
      bus(1'b1, `R_INMASK, 32'hFFFF_FFFF);
      fire(16'h0000, 96'h1, 16'h0000);
      chk(got, 32'h0);
      $display("test window done");
      bus(1'b1, `R_TILEMAP + 12'h004, 32'h10);
      bus(1'b1, `R_LUT + 12'h084, 32'h4);
      bus(1'b1, `R_SLOT + 12'h010, 32'h0000_8000);
      bus(1'b1, `R_DEST, 32'h07);
      bus(1'b1, `R_DEST + 12'h004, {27'h0, `BCAST_DEST});
      fire(16'h0002, 96'h2, 16'h0000);
      chk({got, msg_slot, msg_dest}, {1'b1, 4'h4, 5'h07});
      stamp = msg_time;
      fire(16'h0002, 96'h2, 16'h0000);
      chk({got, msg_broadcast, msg_dest}, {1'b1, 1'b1, `BCAST_DEST});
      chk(msg_time - stamp, `TIME_STEP * 14);
      chk(msg_event, 32'h2);
      fire(16'h0002, 96'h2, 16'h0002);
      chk({got, msg_slot, msg_dest}, {1'b1, 4'h0, 5'h00});
      $display("test destination done");
      bus(1'b1, `R_SLOT + 12'h014, 32'h0000_0201);
      bus(1'b1, `R_LUT + 12'h004, 32'h5);
      for (int i = 0; i < 3; i++) begin
         fire(16'h0004, 96'h0, 16'h0000);
         chk(got, (i != 1));
      end
      throttle <= 1'b1;
      fire(16'h0004, 96'h0, 16'h0000);
      chk(got, 32'h0);
      throttle <= 1'b0;
      rd(`R_CNT_SENT, 32'h6);
      rd(`R_CNT_DEAD, 32'h1);
      rd(`R_CNT_PRESC, 32'h1);
      chk(msg_seen, 32'h6);
      $display("test inhibit done");
      @(posedge clk);
      {cal_low, heavy, solicited} <= {16'h0008, 12'h004, 1'b1};
      @(posedge clk);
      {cal_low, heavy, solicited} <= '0;
      repeat (12) @(posedge clk);
      rd(`R_LASTCOND, 32'h0000_004A);
      rd(`R_LASTLOW, 32'h0008_0000);
      rd(`R_LASTHIGH, 32'h0004_0000);
      chk(msg_seen, 32'h7);
      $display("test conditions done");
      @(posedge clk);
      second_mark <= 1'b1;
      @(posedge clk);
      second_mark <= 1'b0;
      rd(`R_PPS_COUNT, 32'h1);
      $display("test second mark done");
      test_done;
   end
endmodule : test_global_trigger_scheduler
